// *** include/sss_pkg.sv ***
// screen sequencer and saver: shared constants, carriers and helpers
// assumes a one-second tick from elsewhere and pulsed key inputs
package sss_pkg;

   // ---------------------------------------------------------------
   // widths and limits
   // ---------------------------------------------------------------
   localparam int SSS_NSCR = 8;
   localparam logic [11:0] SSS_DWELL_MIN = 12'h001;
   localparam logic [11:0] SSS_DWELL_MAX = 12'hE10;
   localparam logic [7:0] SSS_MASK_RST = 8'hFF;
   localparam logic [7:0] SSS_MASK_KEEP = 8'h01;

   // ---------------------------------------------------------------
   // factory defaults, for the settings store that feeds the ports
   // ---------------------------------------------------------------
   localparam logic SSS_MODE_DFLT = 1'b0;
   localparam logic [7:0] SSS_OP_BRIGHT_DFLT = 8'h7F;
   localparam logic [15:0] SSS_TIMEOUT_DFLT = 16'h0384;
   localparam logic SSS_PREC_DFLT = 1'b0;

   // ---------------------------------------------------------------
   // saver modes
   // ---------------------------------------------------------------
   localparam logic [1:0] SSS_SS_OFF = 2'h0;
   localparam logic [1:0] SSS_SS_DIM = 2'h1;
   localparam logic [1:0] SSS_SS_SCROLL = 2'h2;
   localparam logic [1:0] SSS_SS_BLANK = 2'h3;
   localparam logic [1:0] SSS_SS_DFLT = SSS_SS_SCROLL;

   typedef struct packed {
      logic up;
      logic down;
      logic right;
      logic enter;
      logic esc;
      logic other;
   } sss_keys_t;

   typedef struct packed {
      logic [7:0] bright;
      logic on;
      logic scroll;
      logic extra_digit;
   } sss_disp_t;

   // next enabled screen in the chosen direction, circular
   function automatic logic [2:0] sss_step(input logic [2:0] cur,
                                           input logic [7:0] m,
                                           input logic fwd);
      logic [2:0] idx;
      logic [2:0] res;
      logic found;
      idx = cur;
      res = cur;
      found = 1'b0;
      for (int i = 0; i < SSS_NSCR; i++) begin
         idx = fwd ? idx + 3'h1 : idx - 3'h1;
         if (!found && m[idx]) begin
            res = idx;
            found = 1'b1;
         end
      end
      return res;
   endfunction : sss_step

   // dwell time forced into its legal range
   function automatic logic [11:0] sss_clamp(input logic [11:0] v);
      logic [11:0] r;
      r = v;
      if (v < SSS_DWELL_MIN) begin
         r = SSS_DWELL_MIN;
      end else if (v > SSS_DWELL_MAX) begin
         r = SSS_DWELL_MAX;
      end
      return r;
   endfunction : sss_clamp

endpackage : sss_pkg

// *** core/sss_core.sv ***
// screen sequencer and saver for the local display panel
// assumes key inputs are one-cycle pulses synchronous to clk_i and that
// sec_tick_i pulses for one cycle once per second
//
// Notes on behaviour
// - static mode: up pages forward, down back
// - paging wraps circularly past last screen
// - masked screens skipped in every mode
// - first screen can never be masked
// - mode input picks static or dynamic
// - dynamic dwell whole seconds, 1 to 3600
// - eight-bit enable mask, all set at reset
// - right key toggles selected pending mask bit
// - enter commits mask and requests save
// - eight-bit operating brightness when saver idle
// - saver modes: off, dim, scroll, blank
// - saver starts when idle seconds reach timeout
// - any key restores brightness, clears timer
// - dim saver uses separate 7-bit brightness
// - saver settings frozen while saver active
// - scroll saver keeps operating brightness
// - elevated precision adds one fractional digit
`timescale 1ns/1ns

module sss_core (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic sec_tick_i,
   input wire sss_pkg::sss_keys_t keys_i,
   input wire logic edit_i,
   input wire logic dyn_mode_i,
   input wire logic [11:0] dwell_s_i,
   input wire logic [7:0] op_bright_i,
   input wire logic [1:0] ss_mode_i,
   input wire logic [15:0] ss_timeout_i,
   input wire logic [6:0] ss_bright_i,
   input wire logic elevated_i,
   output logic [2:0] screen_o,
   output logic [7:0] mask_o,
   output logic [7:0] edit_mask_o,
   output logic [2:0] edit_sel_o,
   output logic mask_save_o,
   output logic saver_active_o,
   output sss_pkg::sss_disp_t disp_o
);
   import sss_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SS_IDLE = 2'b01,
      SS_ON = 2'b10
   } sss_ss_state_t;

   sss_ss_state_t ss_q;
   sss_ss_state_t ss_d;
   logic [2:0] scr_q;
   logic [2:0] scr_d;
   logic [7:0] mask_q;
   logic [7:0] pend_q;
   logic [2:0] sel_q;
   logic edit_q;
   logic save_q;
   logic [11:0] dwell_cnt_q;
   logic [15:0] idle_cnt_q;
   logic [1:0] ss_mode_q;
   logic [6:0] ss_bright_q;
   sss_disp_t disp_q;
   sss_disp_t disp_d;
   logic [7:0] eff_mask;
   logic activity;
   logic wake;
   logic page_up;
   logic page_dn;
   logic dwell_done;
   logic [11:0] dwell_lim;

   // ---------------------------------------------------------------
   // key decode
   // ---------------------------------------------------------------
   assign activity = keys_i.up | keys_i.down | keys_i.right
                   | keys_i.enter | keys_i.esc | keys_i.other;
   // the press that wakes the panel is swallowed so the operator does
   // not page blind while the screen is dark or scrolling
   assign wake = activity && (ss_q == SS_ON);
   assign page_up = keys_i.up && !edit_i && !dyn_mode_i && !wake;
   assign page_dn = keys_i.down && !edit_i && !dyn_mode_i && !wake;

   assign eff_mask = mask_q | SSS_MASK_KEEP;
   assign dwell_lim = sss_clamp(dwell_s_i);
   assign dwell_done = dyn_mode_i && sec_tick_i
                     && (dwell_cnt_q + 12'h001 >= dwell_lim);

   // ---------------------------------------------------------------
   // screen selection
   // ---------------------------------------------------------------
   always_comb begin
      scr_d = scr_q;
      if (!eff_mask[scr_q]) begin
         scr_d = sss_step(scr_q, eff_mask, 1'b1);
      end else if (page_up) begin
         scr_d = sss_step(scr_q, eff_mask, 1'b1);
      end else if (page_dn) begin
         scr_d = sss_step(scr_q, eff_mask, 1'b0);
      end else if (dwell_done) begin
         scr_d = sss_step(scr_q, eff_mask, 1'b1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scr_q <= 3'h0;
      end else begin
         scr_q <= scr_d;
      end
   end

   // ---------------------------------------------------------------
   // dwell timer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dwell_cnt_q <= 12'h000;
      end else if (scr_d != scr_q || !dyn_mode_i) begin
         dwell_cnt_q <= 12'h000;
      end else if (sec_tick_i) begin
         dwell_cnt_q <= dwell_cnt_q + 12'h001;
      end
   end

   // ---------------------------------------------------------------
   // mask editing
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edit_q <= 1'b0;
      end else begin
         edit_q <= edit_i;
      end
   end

   // pending copy shows the markers; live mask untouched until enter
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_q <= SSS_MASK_RST;
         sel_q <= 3'h0;
      end else if (edit_i && !edit_q) begin
         pend_q <= eff_mask;
         sel_q <= 3'h0;
      end else if (edit_i && !wake) begin
         if (keys_i.right) begin
            pend_q <= (pend_q ^ (8'h01 << sel_q)) | SSS_MASK_KEEP;
         end
         if (keys_i.up) begin
            sel_q <= sel_q + 3'h1;
         end else if (keys_i.down) begin
            sel_q <= sel_q - 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_q <= SSS_MASK_RST;
         save_q <= 1'b0;
      end else begin
         save_q <= 1'b0;
         if (edit_i && edit_q && keys_i.enter && !wake) begin
            mask_q <= pend_q | SSS_MASK_KEEP;
            save_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // screensaver
   // ---------------------------------------------------------------
   always_comb begin
      ss_d = ss_q;
      case (ss_q)
         SS_IDLE: begin
            if (!activity && ss_mode_q != SSS_SS_OFF
                && idle_cnt_q >= ss_timeout_i) begin
               ss_d = SS_ON;
            end
         end
         SS_ON: begin
            if (activity) begin
               ss_d = SS_IDLE;
            end
         end
         default: begin
            ss_d = SS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ss_q <= SS_IDLE;
      end else begin
         ss_q <= ss_d;
      end
   end

   // counts from reset, then from the latest key; saturates
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         idle_cnt_q <= 16'h0000;
      end else if (activity) begin
         idle_cnt_q <= 16'h0000;
      end else if (sec_tick_i && idle_cnt_q != 16'hFFFF) begin
         idle_cnt_q <= idle_cnt_q + 16'h0001;
      end
   end

   // settings track the inputs only while the saver is idle
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ss_mode_q <= SSS_SS_DFLT;
         ss_bright_q <= 7'h00;
      end else if (ss_q == SS_IDLE) begin
         ss_mode_q <= ss_mode_i;
         ss_bright_q <= ss_bright_i;
      end
   end

   // ---------------------------------------------------------------
   // panel drive
   // ---------------------------------------------------------------
   always_comb begin
      disp_d.bright = op_bright_i;
      disp_d.on = 1'b1;
      disp_d.scroll = 1'b0;
      disp_d.extra_digit = elevated_i;
      if (ss_d == SS_ON) begin
         case (ss_mode_q)
            SSS_SS_DIM: begin
               disp_d.bright = {1'b0, ss_bright_q};
            end
            SSS_SS_SCROLL: begin
               disp_d.scroll = 1'b1;
            end
            SSS_SS_BLANK: begin
               disp_d.on = 1'b0;
               disp_d.bright = 8'h00;
            end
            default: begin
               disp_d.on = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         disp_q <= '{bright: SSS_OP_BRIGHT_DFLT, on: 1'b1, scroll: 1'b0,
                     extra_digit: SSS_PREC_DFLT};
      end else begin
         disp_q <= disp_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign screen_o = scr_q;
   assign mask_o = eff_mask;
   assign edit_mask_o = pend_q;
   assign edit_sel_o = sel_q;
   assign mask_save_o = save_q;
   assign saver_active_o = (ss_q == SS_ON);
   assign disp_o = disp_q;

endmodule : sss_core

// *** verification/sss_core_assertions.sv ***
// port assertions for sss_core, one clock domain
// assumes keys_i carries one-cycle pulses from the panel
`timescale 1ns/1ns
module sss_core_assertions (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire sss_pkg::sss_keys_t keys_i,
   input wire logic edit_i,
   input wire logic dyn_mode_i,
   input wire logic [7:0] op_bright_i,
   input wire logic [1:0] ss_mode_i,
   input wire logic [6:0] ss_bright_i,
   input wire logic elevated_i,
   input wire logic [2:0] screen_o,
   input wire logic [7:0] mask_o,
   input wire logic [7:0] edit_mask_o,
   input wire logic mask_save_o,
   input wire logic saver_active_o,
   input wire sss_pkg::sss_disp_t disp_o
);
   import sss_pkg::*;
   // -----------------------------------------------------------
   // checks
   // -----------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   logic pg;
   // full mask only, so the expected step needs no skip logic
   assign pg = !dyn_mode_i && !edit_i && !saver_active_o && mask_o == 8'hFF;
   sequence commit_s;
      edit_i && $past(edit_i) && keys_i.enter && !saver_active_o;
   endsequence
   sequence pulse_s;
      mask_save_o ##1 !mask_save_o;
   endsequence
   bit_keep_a: assert property (mask_o[0] && edit_mask_o[0])
      else $error("screen one masked");
   up_page_a: assert property (pg && keys_i.up |=>
      screen_o == $past(screen_o) + 3'h1) else $error("up step wrong");
   down_page_a: assert property (pg && keys_i.down && !keys_i.up |=>
      screen_o == $past(screen_o) - 3'h1) else $error("down step wrong");
   shown_ok_a: assert property (!$changed(mask_o) |->
      mask_o[screen_o]) else $error("masked screen shown");
   commit_save_a: assert property (commit_s |=> pulse_s)
      else $error("commit pulse wrong");
   save_cause_a: assert property (mask_save_o || $changed(mask_o) |->
      $past(keys_i.enter) && $past(edit_i)) else $error("stray commit");
   idle_bright_a: assert property (!saver_active_o |->
      disp_o.on && !disp_o.scroll && disp_o.bright == $past(op_bright_i)
      && disp_o.extra_digit == $past(elevated_i)) else $error("idle disp");
   wake_a: assert property (keys_i != '0 |=> !saver_active_o)
      else $error("activity ignored");
   dim_level_a: assert property ($rose(saver_active_o) &&
      $past(ss_mode_i) == SSS_SS_DIM |-> disp_o.bright ==
      {1'b0, $past(ss_bright_i)}) else $error("dim level wrong");
   scroll_keep_a: assert property ($rose(saver_active_o) &&
      $past(ss_mode_i) == SSS_SS_SCROLL |-> disp_o.scroll &&
      disp_o.bright == $past(op_bright_i)) else $error("scroll level");
   saver_hold_a: assert property (saver_active_o &&
      $past(saver_active_o) && !disp_o.scroll |-> $stable(disp_o.bright))
      else $error("saver level moved");
endmodule : sss_core_assertions
bind sss_core sss_core_assertions u_chk (.*);

// *** verification/sss_panel_model.sv ***
// panel side: joystick, escape key and the seconds tick
// assumes the bench calls drive from one thread only
`timescale 1ns/1ns
module sss_panel_model (
   input wire logic clk_i,
   output sss_pkg::sss_keys_t keys_o,
   output logic tick_o
);
   import sss_pkg::*;
   initial begin
      keys_o = '0;
      tick_o = 1'b0;
   end
   // one clock wide, launched off the falling edge, never at sampling
   task automatic drive(input logic [6:0] v);
      @(negedge clk_i);
      {tick_o, keys_o} = v;
      @(negedge clk_i);
      {tick_o, keys_o} = 7'h00;
   endtask : drive
endmodule : sss_panel_model

// *** verification/screen_sequencer_saver_tb.sv ***
// self-checking bench for sss_core
// assumes sss_panel_model drives keys and ticks
`timescale 1ns/1ns
`define CHK(n,e,s) begin checked++; if ((e) !== (s)) begin err_total++; \
$display("BAD %s exp %h got %h", n, e, s); end end
module screen_sequencer_saver_tb;
   import sss_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i;
   logic edit_i;
   logic dyn_mode_i;
   logic elevated_i;
   logic [11:0] dwell_s_i;
   logic [7:0] op_bright_i;
   logic [1:0] ss_mode_i;
   logic [15:0] ss_timeout_i;
   logic [6:0] ss_bright_i;
   sss_keys_t keys;
   sss_disp_t disp_o;
   logic tick, mask_save_o, saver_active_o;
   logic [2:0] screen_o, edit_sel_o, cur;
   logic [7:0] mask_o, edit_mask_o, m;
   int err_total = 0;
   int checked = 0;
   initial forever #4 clk_i = ~clk_i;
   sss_panel_model u_pan (.clk_i(clk_i), .keys_o(keys), .tick_o(tick));
   sss_core u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .sec_tick_i(tick),
      .keys_i(keys), .edit_i(edit_i), .dyn_mode_i(dyn_mode_i),
      .dwell_s_i(dwell_s_i), .op_bright_i(op_bright_i),
      .ss_mode_i(ss_mode_i), .ss_timeout_i(ss_timeout_i),
      .ss_bright_i(ss_bright_i), .elevated_i(elevated_i),
      .screen_o(screen_o), .mask_o(mask_o), .edit_mask_o(edit_mask_o),
      .edit_sel_o(edit_sel_o), .mask_save_o(mask_save_o),
      .saver_active_o(saver_active_o), .disp_o(disp_o));
   // -----------------------------------------------------------
   // expectations and drivers
   // -----------------------------------------------------------
   function automatic logic [2:0] nxt(logic [2:0] c, logic [7:0] k, bit f);
      logic [2:0] r;
      r = c;
      do r = f ? r + 3'h1 : r - 3'h1; while (!k[r] && r != c);
      return r;
   endfunction : nxt
   function automatic logic [7:0] sb(logic [1:0] md, logic [6:0] b);
      return md == SSS_SS_DIM ? {1'b0, b} : md == SSS_SS_BLANK ? 8'h00
         : op_bright_i;
   endfunction : sb
   task automatic cyc(int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic set_mask(logic [7:0] w);
      edit_i = 1'b1;
      cyc(2);
      for (int i = 0; i < 8; i++) begin
         if (mask_o[i] != w[i]) u_pan.drive(7'h08);
         u_pan.drive(7'h20);
      end
      m = w | 8'h01;
      `CHK("pend", m, edit_mask_o)
      `CHK("sel", 3'h0, edit_sel_o)
      u_pan.drive(7'h04);
      `CHK("mask", m, mask_o)
      `CHK("save", 1'b1, mask_save_o)
      edit_i = 1'b0;
      cyc(2);
      `CHK("save", 1'b0, mask_save_o)
      if (!m[cur]) cur = nxt(cur, m, 1'b1);
      `CHK("screen", cur, screen_o)
   endtask : set_mask
   task automatic page(int n);
      bit f;
      repeat (n) begin
         f = 1'($urandom);
         u_pan.drive(f ? 7'h20 : 7'h10);
         cur = nxt(cur, m, f);
         `CHK("page", cur, screen_o)
      end
   endtask : page
   task automatic dwell(logic [11:0] d, int n);
      dwell_s_i = d;
      dyn_mode_i = 1'b1;
      repeat (2) begin
         repeat (n - 1) u_pan.drive(7'h40);
         `CHK("hold", cur, screen_o)
         u_pan.drive(7'h40);
         cyc(1);
         cur = nxt(cur, m, 1'b1);
         `CHK("dwell", cur, screen_o)
      end
      dyn_mode_i = 1'b0;
   endtask : dwell
   task automatic saver(logic [1:0] md);
      u_pan.drive(7'h01);
      ss_mode_i = md;
      ss_timeout_i = 16'h0004;
      ss_bright_i = 7'($urandom);
      repeat (3) u_pan.drive(7'h40);
      cyc(2);
      `CHK("early", 1'b0, saver_active_o)
      u_pan.drive(7'h40);
      cyc(2);
      `CHK("act", md != SSS_SS_OFF, saver_active_o)
      `CHK("bri", sb(md, ss_bright_i), disp_o.bright)
      ss_bright_i = ~ss_bright_i;
      cyc(2);
      `CHK("on", md != SSS_SS_BLANK, disp_o.on)
      `CHK("scr", md == SSS_SS_SCROLL, disp_o.scroll)
      `CHK("held", sb(md, ~ss_bright_i), disp_o.bright)
      u_pan.drive(7'h02);
      cyc(1);
      `CHK("wake", 1'b0, saver_active_o)
      `CHK("wbri", op_bright_i, disp_o.bright)
   endtask : saver
   task automatic summarize();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   // -----------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------
   initial begin
      rst_b_i = 1'b0;
      edit_i = 1'b0;
      dyn_mode_i = 1'b0;
      elevated_i = 1'b0;
      dwell_s_i = 12'h003;
      op_bright_i = 8'h7F;
      ss_mode_i = SSS_SS_SCROLL;
      ss_timeout_i = 16'hFFFF;
      ss_bright_i = 7'h00;
      cur = 3'h0;
      m = SSS_MASK_RST;
      void'($urandom(32'hB68B));
      cyc(2);
      rst_b_i = 1'b1;
      cyc(1);
      `CHK("rmask", SSS_MASK_RST, mask_o)
      `CHK("rbri", SSS_OP_BRIGHT_DFLT, disp_o.bright)
      page(12);
      set_mask(8'h04);
      page(10);
      repeat (3) begin
         set_mask(8'($urandom));
         page(12);
      end
      dwell(12'h003, 3);
      dwell(12'h000, 1);
      dwell(12'hFFF, 3600);
      // mode 2 is what an unviewed install picks
      for (int i = 0; i < 4; i++) saver(2'(i));
      elevated_i = 1'b1;
      op_bright_i = 8'($urandom);
      cyc(2);
      `CHK("dig", 1'b1, disp_o.extra_digit)
      `CHK("obri", op_bright_i, disp_o.bright)
      summarize();
   end
   initial begin
      #400000;
      err_total++;
      summarize();
   end
endmodule : screen_sequencer_saver_tb
